// file: shared/meas_trig_pkg.sv
// Shared constants and types for the measurement trigger control block
package meas_trig_pkg;

    // ************************************************************
    // Host command opcodes
    // ************************************************************
    localparam logic [4:0] OP_SET_STOP = 5'h00;
    localparam logic [4:0] OP_GET_STOP = 5'h01;
    localparam logic [4:0] OP_SET_START = 5'h02;
    localparam logic [4:0] OP_GET_START = 5'h03;
    localparam logic [4:0] OP_SET_STATE = 5'h04;
    localparam logic [4:0] OP_GET_STATE = 5'h05;
    localparam logic [4:0] OP_SET_LEVEL = 5'h06;
    localparam logic [4:0] OP_GET_LEVEL = 5'h07;
    localparam logic [4:0] OP_SET_TIME = 5'h08;
    localparam logic [4:0] OP_GET_TIME = 5'h09;
    localparam logic [4:0] OP_SET_EDGE = 5'h0a;
    localparam logic [4:0] OP_GET_EDGE = 5'h0b;
    localparam logic [4:0] OP_SET_UNITS = 5'h0c;
    localparam logic [4:0] OP_GET_UNITS = 5'h0d;
    localparam logic [4:0] OP_ZERO_STORE = 5'h0e;
    localparam logic [4:0] OP_SET_ZEROVAL = 5'h0f;
    localparam logic [4:0] OP_GET_ZEROVAL = 5'h10;
    localparam logic [4:0] OP_SET_ZERO_EN = 5'h11;
    localparam logic [4:0] OP_GET_ZERO_EN = 5'h12;

    // ************************************************************
    // Selector codes and limits
    // ************************************************************
    localparam logic [2:0] STOP_NEVER = 3'h0;
    localparam logic [2:0] STOP_EXT = 3'h1;
    localparam logic [2:0] STOP_KEY = 3'h2;
    localparam logic [2:0] STOP_HOST = 3'h3;
    localparam logic [2:0] STOP_LEVEL = 3'h4;
    localparam logic [2:0] STOP_TIME = 3'h5;
    localparam logic [2:0] STOP_MAX = 3'h6;
    localparam logic [1:0] START_CONT = 2'h0;
    localparam logic [1:0] START_EXT = 2'h1;
    localparam logic [1:0] START_KEY = 2'h2;
    localparam logic [1:0] START_HOST = 2'h3;
    localparam logic [3:0] UNITS_MAX = 4'hb;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [2:0] STOP_RESET = 3'h0;
    localparam logic [1:0] START_RESET = 2'h0;
    localparam logic [3:0] UNITS_RESET = 4'h2;
    localparam logic EDGE_RESET = 1'b1;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {ST_ARMED, ST_ACQUIRE, ST_HALTED} acq_state_t;

endpackage

// file: verilog/measurement_trigger_control.sv
// Acquisition start/stop control, zero offset and settings for a meter
`timescale 1ns/1ps

// Summary of operation
// - Stop selector accepts codes 0 to 6; higher codes are ignored.
// - Stop code 0: acquisition never ends by a stop condition.
// - Stop code 1: halt on an active external trigger edge.
// - Stop code 2: halt when the soft key press is reported.
// - Stop code 3: halt when the host writes arm state zero.
// - Stop code 4: halt once a measurement exceeds the level threshold.
// - Stop code 5: halt once the duration since start has elapsed.
// - Arm state 0 means armed, waiting for the start event.
// - Arm state 1 means triggered with at least one measurement done.
// - Level stop: no measurement follows one above the threshold.
// - Time stop: no measurement once elapsed milliseconds exceed duration.
// - Units selector codes 0 to 11, 7 to 10 reserved.
// - Units query returns the selected units code.
// - Zero store copies the present reading into the zero value.
// - With zeroing on, the zero value is subtracted from each reading.
// - Zero value query returns the stored zero value.
// - Stop query returns the stop selector code.
// - Arm state query returns armed or triggered value.
// - Start query returns the start selector code.
// - Start codes: 0 continuous, 1 trigger, 2 soft key, 3 host state 1.
// - Edge select 0 makes falling edges active, 1 rising edges.
module measurement_trigger_control #(
    parameter int DATA_W = 32,
    parameter int MS_CYCLES = meas_trig_pkg::CYCLES_PER_MS
) (
    input wire logic mclk, // 100 MHz clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic cmdValid, // Host command strobe
    input wire logic [4:0] cmdOp, // Command opcode
    input wire logic [DATA_W-1:0] cmdArg, // Command argument
    input wire logic extTrigger, // External trigger input level
    input wire logic softKey, // Soft key press pulse
    input wire logic sampleValid, // Raw reading strobe
    input wire logic [DATA_W-1:0] sampleData, // Raw reading, signed
    output logic measValid, // Accepted measurement strobe
    output logic [DATA_W-1:0] measData, // Zero-corrected measurement
    output logic acquiring, // Acquisition running
    output logic armState, // 0 armed, 1 triggered
    output logic queryValid, // Query answer strobe
    output logic [DATA_W-1:0] queryData, // Query answer
    output logic cmdRefused // Out-of-range argument pulse
);

    // ************************************************************
    // Settings and state
    // ************************************************************
    logic [2:0] stopSel_reg;
    logic [1:0] startSel_reg;
    logic [3:0] unitsSel_reg;
    logic edgeSel_reg;
    logic zeroEn_reg;
    logic [DATA_W-1:0] level_reg;
    logic [DATA_W-1:0] duration_reg;
    logic [DATA_W-1:0] zeroVal_reg;
    logic [DATA_W-1:0] lastRaw_reg;
    logic extPrev_reg;
    logic [31:0] tick_reg;
    logic [DATA_W-1:0] elapsed_reg;
    meas_trig_pkg::acq_state_t state_reg;
    meas_trig_pkg::acq_state_t state_next;

    function automatic logic isOp(input logic [4:0] op);
        isOp = cmdValid && (cmdOp == op);
    endfunction

    // ************************************************************
    // Command and event decode
    // ************************************************************
    // One-hot opcode hit; a plain net so decode follows every command
    wire [18:0] opHit = 19'(cmdValid) << cmdOp;
    wire setStop = opHit[meas_trig_pkg::OP_SET_STOP];
    wire setStart = opHit[meas_trig_pkg::OP_SET_START];
    wire setState = opHit[meas_trig_pkg::OP_SET_STATE];
    wire setUnits = opHit[meas_trig_pkg::OP_SET_UNITS];
    wire stopOk = cmdArg <= DATA_W'(meas_trig_pkg::STOP_MAX);
    wire startOk = cmdArg <= DATA_W'(meas_trig_pkg::START_HOST);
    wire unitsOk = cmdArg <= DATA_W'(meas_trig_pkg::UNITS_MAX);
    wire stateOk = cmdArg <= DATA_W'(1);
    wire hostArm0 = setState && cmdArg == '0;
    wire hostArm1 = setState && cmdArg == DATA_W'(1);
    // Active edge follows the polarity select
    wire extEdge = edgeSel_reg ? (extTrigger && !extPrev_reg)
                               : (!extTrigger && extPrev_reg);
    // Correction ahead of the level compare and measData; the zero store takes the raw reading
    wire [DATA_W-1:0] corrected = zeroEn_reg ?
        sampleData - zeroVal_reg : sampleData;
    wire overLevel = $signed(corrected) > $signed(level_reg);
    wire timeUp = elapsed_reg > duration_reg;
    wire takeMeas = (state_reg == meas_trig_pkg::ST_ACQUIRE) && sampleValid;

    // Start event selection
    wire startHit =
        (startSel_reg == meas_trig_pkg::START_CONT) ||
        (startSel_reg == meas_trig_pkg::START_EXT && extEdge) ||
        (startSel_reg == meas_trig_pkg::START_KEY && softKey) ||
        (startSel_reg == meas_trig_pkg::START_HOST && hostArm1);

    // Stop event selection; code 0 and 6 never stop
    wire stopHit =
        (stopSel_reg == meas_trig_pkg::STOP_EXT && extEdge) ||
        (stopSel_reg == meas_trig_pkg::STOP_KEY && softKey) ||
        (stopSel_reg == meas_trig_pkg::STOP_HOST && hostArm0) ||
        (stopSel_reg == meas_trig_pkg::STOP_LEVEL && takeMeas
            && overLevel) ||
        (stopSel_reg == meas_trig_pkg::STOP_TIME && timeUp);

    // Time measurement may not be taken once the interval has run out
    wire measBlocked = stopSel_reg == meas_trig_pkg::STOP_TIME && timeUp;
    wire msTick = tick_reg == 32'(MS_CYCLES - 1);

    // ************************************************************
    // Acquisition state machine
    // ************************************************************
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            meas_trig_pkg::ST_ARMED: begin
                if (startHit) begin
                    state_next = meas_trig_pkg::ST_ACQUIRE;
                end
            end
            meas_trig_pkg::ST_ACQUIRE: begin
                if (stopHit) begin
                    state_next = meas_trig_pkg::ST_HALTED;
                end else if (hostArm0) begin
                    state_next = meas_trig_pkg::ST_ARMED;
                end
            end
            meas_trig_pkg::ST_HALTED: begin
                if (hostArm0) begin
                    state_next = meas_trig_pkg::ST_ARMED;
                end
            end
            default: begin
                state_next = meas_trig_pkg::ST_ARMED;
            end
        endcase
    end

    // State, edge history and arm flag
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_reg <= meas_trig_pkg::ST_ARMED;
            extPrev_reg <= extTrigger; // Tracks pin: no false edge
            armState <= 1'b0;
            acquiring <= 1'b0;
        end else begin
            state_reg <= state_next;
            extPrev_reg <= extTrigger;
            acquiring <= state_next == meas_trig_pkg::ST_ACQUIRE;
            if (takeMeas && !measBlocked) begin
                armState <= 1'b1;
            end else if (state_next == meas_trig_pkg::ST_ARMED) begin
                armState <= 1'b0;
            end
        end
    end

    // Millisecond timer runs only during acquisition, from the start
    always_ff @(posedge mclk) begin
        if (!rst_n || state_reg != meas_trig_pkg::ST_ACQUIRE) begin
            tick_reg <= '0;
            elapsed_reg <= '0;
        end else if (msTick) begin
            tick_reg <= '0;
            if (!timeUp) begin
                elapsed_reg <= elapsed_reg + DATA_W'(1);
            end
        end else begin
            tick_reg <= tick_reg + 32'h1;
        end
    end

    // ************************************************************
    // Measurement path
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            measValid <= 1'b0;
            measData <= '0;
            lastRaw_reg <= '0;
        end else begin
            measValid <= takeMeas && !measBlocked;
            if (sampleValid) begin
                lastRaw_reg <= sampleData;
                measData <= corrected;
            end
        end
    end

    // ************************************************************
    // Settings written by the host
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            stopSel_reg <= meas_trig_pkg::STOP_RESET;
            startSel_reg <= meas_trig_pkg::START_RESET;
            unitsSel_reg <= meas_trig_pkg::UNITS_RESET;
            edgeSel_reg <= meas_trig_pkg::EDGE_RESET;
            zeroEn_reg <= 1'b0;
            level_reg <= '0;
            duration_reg <= '0;
            zeroVal_reg <= '0;
        end else begin
            if (setStop && stopOk) begin
                stopSel_reg <= cmdArg[2:0];
            end
            if (setStart && startOk) begin
                startSel_reg <= cmdArg[1:0];
            end
            if (setUnits && unitsOk) begin
                unitsSel_reg <= cmdArg[3:0];
            end
            if (isOp(meas_trig_pkg::OP_SET_EDGE)) begin
                edgeSel_reg <= cmdArg[0];
            end
            if (isOp(meas_trig_pkg::OP_SET_ZERO_EN)) begin
                zeroEn_reg <= cmdArg[0];
            end
            if (isOp(meas_trig_pkg::OP_SET_LEVEL)) begin
                level_reg <= cmdArg;
            end
            if (isOp(meas_trig_pkg::OP_SET_TIME)) begin
                duration_reg <= cmdArg;
            end
            // A store from the reading wins over a value in the same cycle
            if (isOp(meas_trig_pkg::OP_ZERO_STORE)) begin
                zeroVal_reg <= lastRaw_reg;
            end else if (isOp(meas_trig_pkg::OP_SET_ZEROVAL)) begin
                zeroVal_reg <= cmdArg;
            end
        end
    end

    // ************************************************************
    // Query answers
    // ************************************************************
    wire isQuery = opHit[meas_trig_pkg::OP_GET_STOP] ||
        opHit[meas_trig_pkg::OP_GET_START] ||
        opHit[meas_trig_pkg::OP_GET_STATE] ||
        opHit[meas_trig_pkg::OP_GET_LEVEL] ||
        opHit[meas_trig_pkg::OP_GET_TIME] ||
        opHit[meas_trig_pkg::OP_GET_EDGE] ||
        opHit[meas_trig_pkg::OP_GET_UNITS] ||
        opHit[meas_trig_pkg::OP_GET_ZEROVAL] ||
        opHit[meas_trig_pkg::OP_GET_ZERO_EN];
    wire [DATA_W-1:0] answer =
        opHit[meas_trig_pkg::OP_GET_STOP] ? DATA_W'(stopSel_reg) :
        opHit[meas_trig_pkg::OP_GET_START] ? DATA_W'(startSel_reg) :
        opHit[meas_trig_pkg::OP_GET_STATE] ? DATA_W'(armState) :
        opHit[meas_trig_pkg::OP_GET_LEVEL] ? level_reg :
        opHit[meas_trig_pkg::OP_GET_TIME] ? duration_reg :
        opHit[meas_trig_pkg::OP_GET_EDGE] ? DATA_W'(edgeSel_reg) :
        opHit[meas_trig_pkg::OP_GET_UNITS] ? DATA_W'(unitsSel_reg) :
        opHit[meas_trig_pkg::OP_GET_ZEROVAL] ? zeroVal_reg :
        DATA_W'(zeroEn_reg);
    // Out-of-range selector arguments leave the setting untouched
    wire badArg = (setStop && !stopOk) || (setStart && !startOk) ||
        (setUnits && !unitsOk) || (setState && !stateOk);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            queryValid <= 1'b0;
            queryData <= '0;
            cmdRefused <= 1'b0;
        end else begin
            queryValid <= isQuery;
            cmdRefused <= badArg;
            if (isQuery) begin
                queryData <= answer;
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    a_stop_range: assert property (
        @(posedge mclk) disable iff (!rst_n)
        stopSel_reg <= meas_trig_pkg::STOP_MAX)
        else $error("stop selector out of range");

    a_never_stops: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (state_reg == meas_trig_pkg::ST_ACQUIRE && stopSel_reg ==
        meas_trig_pkg::STOP_NEVER && !hostArm0) |=> acquiring)
        else $error("acquisition ended with no stop selected");

    a_ext_stop: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (state_reg == meas_trig_pkg::ST_ACQUIRE && extEdge && stopSel_reg
        == meas_trig_pkg::STOP_EXT) |=> state_reg ==
        meas_trig_pkg::ST_HALTED)
        else $error("external trigger did not halt");

    a_key_stop: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (state_reg == meas_trig_pkg::ST_ACQUIRE && softKey && stopSel_reg
        == meas_trig_pkg::STOP_KEY) |=> !acquiring)
        else $error("soft key did not halt");

    a_host_stop: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (state_reg == meas_trig_pkg::ST_ACQUIRE && hostArm0 && stopSel_reg
        == meas_trig_pkg::STOP_HOST) |=> state_reg ==
        meas_trig_pkg::ST_HALTED)
        else $error("host state zero did not halt");

    a_level_stop: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (takeMeas && overLevel && stopSel_reg == meas_trig_pkg::STOP_LEVEL)
        |=> measValid ##1 (!measValid && !acquiring))
        else $error("measurement taken after level reached");

    a_time_stop: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (stopSel_reg == meas_trig_pkg::STOP_TIME && timeUp) |=>
        !measValid)
        else $error("measurement after duration elapsed");

    a_hold_halt: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (state_reg == meas_trig_pkg::ST_HALTED && !hostArm0) |=>
        $stable(state_reg) && !acquiring)
        else $error("halt left without re-arm");

    a_armed_idle: assert property (
        @(posedge mclk) disable iff (!rst_n)
        state_reg == meas_trig_pkg::ST_ARMED |=> !measValid)
        else $error("measurement while armed");

    a_zero_store: assert property (
        @(posedge mclk) disable iff (!rst_n)
        isOp(meas_trig_pkg::OP_ZERO_STORE) |=>
        zeroVal_reg == $past(lastRaw_reg))
        else $error("zero store did not capture reading");

    a_units_query: assert property (
        @(posedge mclk) disable iff (!rst_n)
        isOp(meas_trig_pkg::OP_GET_UNITS) |=> queryValid &&
        queryData == DATA_W'(unitsSel_reg))
        else $error("units query answer wrong");

    a_stop_query: assert property (
        @(posedge mclk) disable iff (!rst_n)
        isOp(meas_trig_pkg::OP_GET_STOP) |=> queryValid &&
        queryData == DATA_W'(stopSel_reg))
        else $error("stop query answer wrong");

endmodule

// file: testbench/host_cmd_model.sv
// Host model: turns bench requests into one-cycle command strobes
`timescale 1ns/1ps
module host_cmd_model (
    input wire logic mclk, // Clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic reqValid, // Bench asks for a command
    input wire logic [4:0] reqOp, // Opcode to send
    input wire logic [31:0] reqArg, // Argument to send
    output logic cmdValid, // Command strobe to the block
    output logic [4:0] cmdOp, // Opcode to the block
    output logic [31:0] cmdArg // Argument to the block
);
    // One command per cycle; an idle bus inverts its word every cycle, so it
    // alternates between the last word and its inverse while cmdValid is low
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cmdValid <= 1'b0;
            cmdOp <= 5'h1f;
            cmdArg <= 32'h0;
        end else if (reqValid) begin
            cmdValid <= 1'b1;
            cmdOp <= reqOp;
            cmdArg <= reqArg;
        end else begin
            cmdValid <= 1'b0;
            cmdOp <= ~cmdOp;
            cmdArg <= ~cmdArg;
        end
    end
endmodule

// file: testbench/measurement_trigger_control_tb.sv
// Self-checking bench for the measurement trigger control block
`timescale 1ns/1ps
module measurement_trigger_control_tb;
    localparam int MSC = 10; // Short millisecond keeps time stops quick
    logic mclk, rst_n, reqValid, extTrigger, softKey, sampleValid;
    logic cmdValid, measValid, acquiring, armState, queryValid, cmdRefused;
    logic [4:0] reqOp, cmdOp;
    logic [31:0] reqArg, cmdArg, sampleData, measData, queryData;
    logic [31:0] zv, lvl, s;
    int failures, comparisons, n;
    integer seed;

    // ****************************************
    // Design, host model, clock
    // ****************************************
    measurement_trigger_control #(.DATA_W(32), .MS_CYCLES(MSC)) dut (
        .mclk(mclk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdOp(cmdOp),
        .cmdArg(cmdArg), .extTrigger(extTrigger), .softKey(softKey),
        .sampleValid(sampleValid), .sampleData(sampleData),
        .measValid(measValid), .measData(measData), .acquiring(acquiring),
        .armState(armState), .queryValid(queryValid),
        .queryData(queryData), .cmdRefused(cmdRefused));
    host_cmd_model host (
        .mclk(mclk), .rst_n(rst_n), .reqValid(reqValid), .reqOp(reqOp),
        .reqArg(reqArg), .cmdValid(cmdValid), .cmdOp(cmdOp),
        .cmdArg(cmdArg));

    // Free-running 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Expected settings and readings, from the rules alone
    function automatic int kept(input int i, input int top);
        return (i > top) ? top : i;
    endfunction

    function automatic logic [31:0] exp_meas(input logic [31:0] raw,
                                             input logic [31:0] zero);
        return raw - zero;
    endfunction

    // Request goes to the host model, which strobes it on the next edge
    task automatic cmd(input logic [4:0] op, input logic [31:0] arg);
        @(posedge mclk);
        reqValid <= 1'b1;
        reqOp <= op;
        reqArg <= arg;
        @(posedge mclk);
        reqValid <= 1'b0;
        @(posedge mclk);
        #1;
    endtask

    // Answer stands for the single cycle after the command is taken
    task automatic qchk(input logic [4:0] op, input logic [31:0] exp);
        cmd(op, 32'h0);
        check(32'(queryValid), 32'h1);
        check(queryData, exp);
    endtask

    task automatic st(input logic [31:0] v);
        cmd(meas_trig_pkg::OP_SET_STATE, v);
    endtask

    task automatic stp(input logic [31:0] v);
        cmd(meas_trig_pkg::OP_SET_STOP, v);
    endtask

    // Every legal code, then one past the top, which must be refused
    task automatic sweep(input logic [4:0] so, input logic [4:0] go,
                         input int top);
        for (int i = 0; i <= top + 1; i++) begin
            cmd(so, 32'(i));
            check(32'(cmdRefused), 32'(i > top));
            qchk(go, 32'(kept(i, top)));
        end
    endtask

    task automatic samp(input logic [31:0] v);
        @(posedge mclk);
        sampleValid <= 1'b1;
        sampleData <= v;
        @(posedge mclk);
        sampleValid <= 1'b0;
        sampleData <= ~v;
        #1;
    endtask

    // Key pulse and/or new trigger level, then a few settling cycles
    task automatic drive(input logic key, input logic trig);
        @(posedge mclk);
        softKey <= key;
        extTrigger <= trig;
        @(posedge mclk);
        softKey <= 1'b0;
        repeat (4) @(posedge mclk);
        #1;
    endtask

    task automatic wait_acq(input logic e);
        for (int i = 0; i < 64 && acquiring !== e; i++) begin
            @(posedge mclk);
            #1;
        end
        check(32'(acquiring), 32'(e));
        if (acquiring !== e) close_out();
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        seed = 32'h9204;
        failures = 0;
        comparisons = 0;
        rst_n = 1'b0;
        reqValid = 1'b0;
        reqOp = 5'h0;
        reqArg = 32'h0;
        extTrigger = 1'b0;
        softKey = 1'b0;
        sampleValid = 1'b0;
        sampleData = 32'h0;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        check(32'(armState), 32'h0);
        qchk(meas_trig_pkg::OP_GET_STOP, 32'h0);
        qchk(meas_trig_pkg::OP_GET_START, 32'h0);
        qchk(meas_trig_pkg::OP_GET_UNITS, 32'h2);
        qchk(meas_trig_pkg::OP_GET_EDGE, 32'h1);
        wait_acq(1'b1);
        $display("test reset defaults done");
        sweep(meas_trig_pkg::OP_SET_UNITS,
              meas_trig_pkg::OP_GET_UNITS, 11);
        sweep(meas_trig_pkg::OP_SET_STOP,
              meas_trig_pkg::OP_GET_STOP, 6);
        sweep(meas_trig_pkg::OP_SET_START,
              meas_trig_pkg::OP_GET_START, 3);
        cmd(meas_trig_pkg::OP_SET_START, 32'h0);
        stp(32'h0);
        // Stop code 5 with zero duration halted the run: re-arm
        st(32'h0);
        wait_acq(1'b1);
        $display("test selector sweeps done");
        // Random zero value first, then one captured from a reading
        zv = $random(seed);
        cmd(meas_trig_pkg::OP_SET_ZEROVAL, zv);
        qchk(meas_trig_pkg::OP_GET_ZEROVAL, zv);
        cmd(meas_trig_pkg::OP_SET_ZERO_EN, 32'h1);
        qchk(meas_trig_pkg::OP_GET_ZERO_EN, 32'h1);
        s = $random(seed);
        samp(s);
        check(32'(measValid), 32'h1);
        check(measData, exp_meas(s, zv));
        s = $random(seed);
        samp(s);
        cmd(meas_trig_pkg::OP_ZERO_STORE, 32'h0);
        qchk(meas_trig_pkg::OP_GET_ZEROVAL, s);
        samp(s + 32'h5);
        check(measData, exp_meas(s + 32'h5, s));
        cmd(meas_trig_pkg::OP_SET_ZERO_EN, 32'h0);
        $display("test zero offset done");
        drive(1'b1, 1'b1);
        drive(1'b1, 1'b0);
        check(32'(acquiring), 32'h1);
        $display("test never stop done");
        // Host start: stays armed until the host writes state one
        cmd(meas_trig_pkg::OP_SET_START, 32'h3);
        st(32'h0);
        repeat (4) @(posedge mclk);
        samp($random(seed));
        check(32'(measValid), 32'h0);
        check(32'(acquiring), 32'h0);
        qchk(meas_trig_pkg::OP_GET_STATE, 32'h0);
        st(32'h1);
        wait_acq(1'b1);
        samp($random(seed));
        check(32'(armState), 32'h1);
        qchk(meas_trig_pkg::OP_GET_STATE, 32'h1);
        // Soft key, then an active trigger edge, as start events
        cmd(meas_trig_pkg::OP_SET_START, 32'h2);
        st(32'h0);
        wait_acq(1'b0);
        drive(1'b1, 1'b0);
        wait_acq(1'b1);
        cmd(meas_trig_pkg::OP_SET_START, 32'h1);
        st(32'h0);
        wait_acq(1'b0);
        drive(1'b0, 1'b1);
        wait_acq(1'b1);
        cmd(meas_trig_pkg::OP_SET_START, 32'h0);
        $display("test host start done");
        stp(32'h2);
        drive(1'b1, 1'b0);
        wait_acq(1'b0);
        samp($random(seed));
        check(32'(measValid), 32'h0);
        st(32'h0);
        wait_acq(1'b1);
        $display("test key stop done");
        // Each polarity: the inactive edge is ignored, the active one halts
        for (int p = 0; p < 2; p++) begin
            stp(32'h0);
            cmd(meas_trig_pkg::OP_SET_EDGE, 32'(p));
            qchk(meas_trig_pkg::OP_GET_EDGE, 32'(p));
            drive(1'b0, p[0]);
            stp(32'h1);
            drive(1'b0, ~p[0]);
            check(32'(acquiring), 32'h1);
            drive(1'b0, p[0]);
            wait_acq(1'b0);
            st(32'h0);
            wait_acq(1'b1);
        end
        $display("test trigger stop done");
        stp(32'h3);
        st(32'h0);
        wait_acq(1'b0);
        repeat (5) @(posedge mclk);
        check(32'(acquiring), 32'h0);
        st(32'h0);
        wait_acq(1'b1);
        $display("test host stop done");
        // A reading equal to the level keeps going; one above halts
        lvl = $random(seed) & 32'h00ff_ffff;
        cmd(meas_trig_pkg::OP_SET_LEVEL, lvl);
        qchk(meas_trig_pkg::OP_GET_LEVEL, lvl);
        stp(32'h4);
        samp(lvl);
        check(32'(measValid), 32'h1);
        samp(lvl + 32'h1);
        check(32'(measValid), 32'h1);
        wait_acq(1'b0);
        samp(32'h0);
        check(32'(measValid), 32'h0);
        $display("test level stop done");
        // Halt comes once elapsed milliseconds pass three
        cmd(meas_trig_pkg::OP_SET_TIME, 32'h3);
        qchk(meas_trig_pkg::OP_GET_TIME, 32'h3);
        stp(32'h5);
        st(32'h0);
        wait_acq(1'b1);
        for (n = 0; n < 200 && acquiring === 1'b1; n++) begin
            @(posedge mclk);
            #1;
        end
        check(32'(n >= 4 * MSC - 1 && n <= 4 * MSC + 3), 32'h1);
        samp(32'h0);
        check(32'(measValid), 32'h0);
        $display("test time stop done");
        close_out();
    end

    // Guard against a hang anywhere in the sequence
    initial begin
        #900000;
        $display("timeout in main sequence");
        failures++;
        close_out();
    end
endmodule
